/* fil_defines.svh */
`ifndef FIL_DEFINES_SVH
`define FIL_DEFINES_SVH

// ****************************************************************
// bus and timer widths
// ****************************************************************
`define FIL_AW               19
`define FIL_DW               8
`define FIL_TMR_W            25

// ****************************************************************
// command cycle addresses and data
// ****************************************************************
`define FIL_UNLOCK_ADDR1     15'h5555
`define FIL_UNLOCK_ADDR2     15'h2AAA
`define FIL_DATA_AA          8'hAA
`define FIL_DATA_55          8'h55
`define FIL_CMD_ERASE_SETUP  8'h80
`define FIL_CMD_PROGRAM      8'hA0
`define FIL_CMD_ID_ENTRY     8'h90
`define FIL_CMD_ID_EXIT      8'hF0
`define FIL_CMD_CHIP_ERASE   8'h10
`define FIL_CMD_SECTOR_ERASE 8'h30
`define FIL_CMD_PAGE_ERASE   8'h50
`define FIL_CMD_LOCK_64K     8'h40
`define FIL_CMD_LOCK_16K     8'h70

// ****************************************************************
// address map
// ****************************************************************
`define FIL_LOCK_ADDR        19'h00002
`define FIL_BOOT64_BASE      19'h70000
`define FIL_BOOT16_BASE      19'h7C000
`define FIL_SECTOR_MASK      19'h0FFFF
`define FIL_PAGE_MASK        19'h00FFF
`define FIL_CHIP_MASK        19'h7FFFF
`define FIL_ERASED           8'hFF
`define FIL_ZERO_BYTE        8'h00

// ****************************************************************
// timing
// ****************************************************************
`define FIL_CLK_MHZ          200
`define FIL_US_PER_MS        1000
`define FIL_BYTE_PROG_US     35
`define FIL_BYTE_PROG_MAX_US 50
`define FIL_PAGE_ERASE_MS    20
`define FIL_CHIP_ERASE_MS    75
`define FIL_BYTE_PROG_CYC    (`FIL_BYTE_PROG_US * `FIL_CLK_MHZ)
`define FIL_BYTE_PROG_MAX_CYC (`FIL_BYTE_PROG_MAX_US * `FIL_CLK_MHZ)
`define FIL_PAGE_ERASE_CYC   (`FIL_PAGE_ERASE_MS * `FIL_US_PER_MS * `FIL_CLK_MHZ)
`define FIL_CHIP_ERASE_CYC   (`FIL_CHIP_ERASE_MS * `FIL_US_PER_MS * `FIL_CLK_MHZ)

`endif

/* fil_pkg.sv */
package fil_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_UNL1, SEQ_UNL2, SEQ_ERS3, SEQ_ERS4, SEQ_ERS5, SEQ_PROG
  } fil_seq_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_PROG, OP_SECTOR, OP_PAGE, OP_CHIP
  } fil_op_t;

  typedef struct packed {
    logic wp;
    logic tbl;
    logic soft16;
    logic soft64;
  } fil_lock_t;

endpackage

/* fil_array_mem.sv */
`timescale 1ns/1ps
module fil_array_mem #(
  parameter int AW = 19,
  parameter int DW = 8
) (
  input  wire logic          clk_sys_in,     // system clock
  input  wire logic          rst_b_in,       // async reset, active low
  input  wire logic          we_in,          // write enable
  input  wire logic [AW-1:0] waddr_in,       // write address
  input  wire logic [DW-1:0] wdata_in,       // write data
  input  wire logic          re_in,          // read enable
  input  wire logic [AW-1:0] raddr_in,       // read address
  input  wire logic          bypass_in,      // return bypass data instead
  input  wire logic [DW-1:0] bypass_data_in, // id, lock or status byte
  output logic      [DW-1:0] rdata_out       // registered read data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= '0;
    end else if (re_in) begin
      rdata_out <= bypass_in ? bypass_data_in : mem[raddr_in];
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

/* fil_busy_timer.sv */
`timescale 1ns/1ps
`include "fil_defines.svh"
module fil_busy_timer #(
  parameter int W = `FIL_TMR_W
) (
  input  wire logic         clk_sys_in, // system clock
  input  wire logic         rst_b_in,   // async reset, active low
  input  wire logic         start_in,   // load and run
  input  wire logic [W-1:0] load_in,    // duration in cycles, at least one
  output logic              run_out     // high while counting
);

  logic [W-1:0] cnt;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt     <= '0;
      run_out <= 1'b0;
    end else if (start_in) begin
      cnt     <= load_in - W'(1);
      run_out <= 1'b1;
    end else if (run_out) begin
      if (cnt == '0) begin
        run_out <= 1'b0;
      end else begin
        cnt <= cnt - W'(1);
      end
    end
  end

endmodule

/* fil_id_lock.sv */
`timescale 1ns/1ps
`include "fil_defines.svh"
module fil_id_lock
  import fil_pkg::*;
#(
  parameter logic [7:0] MFR_CODE          = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE          = 8'hC3, // arbitrary value
  parameter int         BYTE_PROG_CYC     = `FIL_BYTE_PROG_CYC,
  parameter int         BYTE_PROG_MAX_CYC = `FIL_BYTE_PROG_MAX_CYC,
  parameter int         PAGE_ERASE_CYC    = `FIL_PAGE_ERASE_CYC,
  parameter int         CHIP_ERASE_CYC    = `FIL_CHIP_ERASE_CYC
) (
  input  wire logic              clk_sys_in,                // 200 MHz system clock
  input  wire logic              rst_b_in,                  // async reset, active low
  input  wire logic [`FIL_AW-1:0] addr_in,                  // byte address
  input  wire logic [`FIL_DW-1:0] wr_data_in,               // write data
  input  wire logic              wr_in,                     // write strobe
  input  wire logic              rd_in,                     // read strobe
  input  wire logic              top_block_lock_strap_b_in, // pin, low locks 64K boot
  input  wire logic              write_protect_strap_b_in,  // pin, low locks the rest
  output logic      [`FIL_DW-1:0] rd_data_out,              // read data, cycle after rd
  output logic                   busy_out,                  // embedded operation running
  output logic                   id_mode_out                // id readout mode active
);

  // ****************************************************************
  // strap synchronisers
  // ****************************************************************
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_meta <= 2'h3;
      strap_sync <= 2'h3;
    end else begin
      strap_meta <= {write_protect_strap_b_in, top_block_lock_strap_b_in};
      strap_sync <= strap_meta;
    end
  end

  // ****************************************************************
  // lock state
  // ****************************************************************
  logic      soft64;
  logic      soft16;
  fil_lock_t lock_now;

  assign lock_now = fil_lock_t'({~strap_sync[1], ~strap_sync[0], soft16, soft64});

  function automatic logic region_blocked(input logic [`FIL_AW-1:0] a, input fil_lock_t l);
    logic b;
    b = l.wp;
    if (a >= `FIL_BOOT16_BASE) begin
      b = l.soft64 | l.tbl | l.soft16;
    end else if (a >= `FIL_BOOT64_BASE) begin
      b = l.soft64 | l.tbl;
    end
    return b;
  endfunction

  // ****************************************************************
  // command decode
  // ****************************************************************
  fil_seq_t seq;
  fil_seq_t next_seq;
  fil_op_t  op;
  logic     id_mode;
  logic     op_busy;

  wire at_addr1   = (addr_in[14:0] == `FIL_UNLOCK_ADDR1);
  wire at_addr2   = (addr_in[14:0] == `FIL_UNLOCK_ADDR2);
  wire wr_take    = wr_in && !op_busy;
  wire is_aa1     = at_addr1 && (wr_data_in == `FIL_DATA_AA);
  wire is_552     = at_addr2 && (wr_data_in == `FIL_DATA_55);
  wire is_f0      = (wr_data_in == `FIL_CMD_ID_EXIT);
  wire short_exit = wr_take && is_f0 && (seq != SEQ_PROG);

  logic    set_id;
  logic    clr_id;
  logic    set_l64;
  logic    set_l16;
  fil_op_t start_op;

  // steps advance only on a taken write transaction
  always_comb begin
    next_seq = seq;
    set_id   = 1'b0;
    clr_id   = short_exit;
    set_l64  = 1'b0;
    set_l16  = 1'b0;
    start_op = OP_NONE;
    if (wr_take) begin
      next_seq = SEQ_IDLE;
      unique case (seq)
        SEQ_IDLE: begin
          if (is_aa1) begin
            next_seq = SEQ_UNL1;
          end
        end
        SEQ_UNL1: begin
          if (is_552) begin
            next_seq = SEQ_UNL2;
          end
        end
        SEQ_UNL2: begin
          if (at_addr1) begin
            if (wr_data_in == `FIL_CMD_ID_ENTRY) begin
              set_id = 1'b1;
            end
            if (is_f0) begin
              clr_id = 1'b1;
            end
            if (wr_data_in == `FIL_CMD_PROGRAM) begin
              next_seq = SEQ_PROG;
            end
            if (wr_data_in == `FIL_CMD_ERASE_SETUP) begin
              next_seq = SEQ_ERS3;
            end
          end
        end
        SEQ_ERS3: begin
          if (is_aa1) begin
            next_seq = SEQ_ERS4;
          end
        end
        SEQ_ERS4: begin
          if (is_552) begin
            next_seq = SEQ_ERS5;
          end
        end
        SEQ_ERS5: begin
          if (wr_data_in == `FIL_CMD_SECTOR_ERASE) begin
            start_op = OP_SECTOR;
          end
          if (wr_data_in == `FIL_CMD_PAGE_ERASE) begin
            start_op = OP_PAGE;
          end
          if (at_addr1 && (wr_data_in == `FIL_CMD_CHIP_ERASE)) begin
            start_op = OP_CHIP;
          end
          set_l64 = at_addr1 && (wr_data_in == `FIL_CMD_LOCK_64K);
          set_l16 = at_addr1 && (wr_data_in == `FIL_CMD_LOCK_16K);
        end
        SEQ_PROG: begin
          start_op = OP_PROG;
        end
      endcase
    end
  end

  // ****************************************************************
  // operation start and protection
  // ****************************************************************
  logic [`FIL_AW-1:0] erase_mask;
  logic               op_blocked;
  logic               op_go;
  logic [`FIL_TMR_W-1:0] op_cycles;

  assign erase_mask = (start_op == OP_SECTOR) ? `FIL_SECTOR_MASK :
                      (start_op == OP_PAGE)   ? `FIL_PAGE_MASK   : `FIL_CHIP_MASK;
  assign op_blocked = (start_op == OP_CHIP) ? (|lock_now) : region_blocked(addr_in, lock_now);
  assign op_go      = (start_op != OP_NONE) && !op_blocked;
  assign op_cycles  = (start_op == OP_PROG) ? `FIL_TMR_W'(BYTE_PROG_CYC) :
                      (start_op == OP_CHIP) ? `FIL_TMR_W'(CHIP_ERASE_CYC) :
                                              `FIL_TMR_W'(PAGE_ERASE_CYC);

  logic tmr_run;

  fil_busy_timer #(
    .W (`FIL_TMR_W)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .start_in   (op_go),
    .load_in    (op_cycles),
    .run_out    (tmr_run)
  );

  // ****************************************************************
  // erase walk, program write and sequencing state
  // ****************************************************************
  logic [`FIL_AW-1:0] walk_addr;
  logic [`FIL_AW-1:0] walk_last;
  logic               walk_active;
  logic               poll_bit;
  logic               toggle;

  wire op_done = op_busy && !op_go && !tmr_run && !walk_active;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seq     <= SEQ_IDLE;
      id_mode <= 1'b0;
      soft64  <= 1'b0;
      soft16  <= 1'b0;
    end else begin
      seq     <= next_seq;
      id_mode <= set_id | (id_mode & ~clr_id);
      soft64  <= soft64 | set_l64;
      soft16  <= soft16 | set_l16;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      op       <= OP_NONE;
      op_busy  <= 1'b0;
      poll_bit <= 1'b0;
    end else if (op_go) begin
      op       <= start_op;
      op_busy  <= 1'b1;
      poll_bit <= (start_op == OP_PROG) ? ~wr_data_in[7] : 1'b0;
    end else if (op_done) begin
      op      <= OP_NONE;
      op_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      walk_addr   <= '0;
      walk_last   <= '0;
      walk_active <= 1'b0;
    end else if (op_go && (start_op != OP_PROG)) begin
      walk_addr   <= addr_in & ~erase_mask;
      walk_last   <= addr_in | erase_mask;
      walk_active <= 1'b1;
    end else if (walk_active) begin
      walk_addr   <= walk_addr + `FIL_AW'(1);
      walk_active <= (walk_addr != walk_last);
    end
  end

  // toggle bit flips on every status read
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      toggle <= 1'b0;
    end else if (rd_in && op_busy) begin
      toggle <= ~toggle;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  wire                codes_addr = (addr_in[`FIL_AW-1:1] == '0);
  wire                lock_addr  = (addr_in == `FIL_LOCK_ADDR);
  wire [`FIL_DW-1:0]  id_byte    = codes_addr ? (addr_in[0] ? DEV_CODE : MFR_CODE) :
                                   lock_addr  ? {4'h0, lock_now} :
                                                `FIL_ZERO_BYTE;
  wire [`FIL_DW-1:0]  stat_byte  = {poll_bit, toggle, 6'h00};
  wire                mem_we     = walk_active | (op_go && (start_op == OP_PROG));
  wire [`FIL_AW-1:0]  mem_waddr  = walk_active ? walk_addr : addr_in;
  wire [`FIL_DW-1:0]  mem_wdata  = walk_active ? `FIL_ERASED : wr_data_in;

  fil_array_mem #(
    .AW (`FIL_AW),
    .DW (`FIL_DW)
  ) u_mem (
    .clk_sys_in     (clk_sys_in),
    .rst_b_in       (rst_b_in),
    .we_in          (mem_we),
    .waddr_in       (mem_waddr),
    .wdata_in       (mem_wdata),
    .re_in          (rd_in),
    .raddr_in       (addr_in),
    .bypass_in      (op_busy | id_mode),
    .bypass_data_in (op_busy ? stat_byte : id_byte),
    .rdata_out      (rd_data_out)
  );

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out    <= 1'b0;
      id_mode_out <= 1'b0;
    end else begin
      busy_out    <= op_busy | op_go;
      id_mode_out <= set_id | (id_mode & ~clr_id);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [`FIL_TMR_W-1:0] prog_age;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prog_age <= '0;
    end else if (op_busy && (op == OP_PROG)) begin
      prog_age <= prog_age + `FIL_TMR_W'(1);
    end else begin
      prog_age <= '0;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  property p_id_mfr;
    rd_in && id_mode && !op_busy && (addr_in == '0) |=> rd_data_out == MFR_CODE;
  endproperty
  a_id_mfr: assert property (p_id_mfr) else $error("maker code not returned");

  property p_id_dev;
    rd_in && id_mode && !op_busy && codes_addr && addr_in[0] |=> rd_data_out == DEV_CODE;
  endproperty
  a_id_dev: assert property (p_id_dev) else $error("device code not returned");

  property p_lock_soft;
    rd_in && id_mode && !op_busy && lock_addr
      |=> rd_data_out[1:0] == {$past(soft16), $past(soft64)};
  endproperty
  a_lock_soft: assert property (p_lock_soft) else $error("soft lock bits wrong");

  property p_lock_tbl;
    rd_in && id_mode && !op_busy && lock_addr |=> rd_data_out[2] == !$past(strap_sync[0]);
  endproperty
  a_lock_tbl: assert property (p_lock_tbl) else $error("strap lock bit 2 wrong");

  property p_lock_wp;
    rd_in && id_mode && !op_busy && lock_addr |=> rd_data_out[3] == !$past(strap_sync[1]);
  endproperty
  a_lock_wp: assert property (p_lock_wp) else $error("strap lock bit 3 wrong");

  property p_lock_upper;
    rd_in && id_mode && !op_busy && lock_addr |=> rd_data_out[7:4] == 4'h0;
  endproperty
  a_lock_upper: assert property (p_lock_upper) else $error("lock upper bits not zero");

  property p_short_exit;
    wr_in && !op_busy && is_f0 && (seq != SEQ_PROG) |=> !id_mode ##1 !id_mode_out;
  endproperty
  a_short_exit: assert property (p_short_exit) else $error("F0 write did not exit");

  property p_entry;
    wr_in && !op_busy && (seq == SEQ_UNL2) && at_addr1 && (wr_data_in == `FIL_CMD_ID_ENTRY)
      |=> id_mode && id_mode_out;
  endproperty
  a_entry: assert property (p_entry) else $error("entry sequence ignored");

  property p_exit_array;
    $fell(id_mode) |-> !id_mode_out && (seq == SEQ_IDLE);
  endproperty
  a_exit_array: assert property (p_exit_array) else $error("exit left id readout active");

  property p_seq_hold;
    !wr_in |=> $stable(seq);
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("sequence moved without write");

  property p_prog_bound;
    prog_age <= `FIL_TMR_W'(BYTE_PROG_MAX_CYC);
  endproperty
  a_prog_bound: assert property (p_prog_bound) else $error("byte program too long");

endmodule

/* fil_host_model.sv */
`timescale 1ns/1ps
// ********************************
// host bus master model
// ********************************
module fil_host_model #(
  parameter int PU_READ_CYC  = 20,
  parameter int PU_WRITE_CYC = 40
) (
  input  wire logic        clk_sys_in,  // system clock
  input  wire logic        rst_b_in,    // reset, active low
  input  wire logic [7:0]  rd_data_in,  // read data from device
  output logic      [18:0] addr_out,    // byte address
  output logic      [7:0]  wr_data_out, // write data
  output logic             wr_out,      // write strobe
  output logic             rd_out       // read strobe
);
  int up_cnt;

  initial begin
    addr_out = 19'h00000;
    wr_data_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // power-up waits are scaled down to keep the run short
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_cnt <= 0;
    end else if (up_cnt < PU_WRITE_CYC) begin
      up_cnt <= up_cnt + 1;
    end
  end

  // one call is one command cycle; idle bus lines flip to stale inverses
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    while (up_cnt < PU_WRITE_CYC) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask

  task automatic rd(input logic [18:0] a, output logic [7:0] d);
    while (up_cnt < PU_READ_CYC) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1 d = rd_data_in;
  endtask

  task automatic unlock(input logic [7:0] cmd);
    wr(19'h05555, 8'hAA);
    wr(19'h02AAA, 8'h55);
    wr(19'h05555, cmd);
  endtask

  task automatic erase6(input logic [18:0] a, input logic [7:0] cmd);
    unlock(8'h80);
    wr(19'h05555, 8'hAA);
    wr(19'h02AAA, 8'h55);
    wr(a, cmd);
  endtask
endmodule

/* tb_fil_id_lock.sv */
`timescale 1ns/1ps
module tb_fil_id_lock;
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // arbitrary value
  localparam int PROG_MAX = 12;
  localparam int PAGE_LEN = 4096;

  logic        clk;
  logic        rst_b;
  logic        tbl_b;
  logic        wp_b;
  logic [18:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        busy;
  logic        id_mode;
  int          fail_count = 0;
  int          num_checks = 0;

  fil_id_lock #(
    .BYTE_PROG_CYC     (8),
    .BYTE_PROG_MAX_CYC (PROG_MAX),
    .PAGE_ERASE_CYC    (20),
    .CHIP_ERASE_CYC    (40)
  ) fil_id_lock_i (
    .clk_sys_in                (clk),
    .rst_b_in                  (rst_b),
    .addr_in                   (addr),
    .wr_data_in                (wdata),
    .wr_in                     (wr),
    .rd_in                     (rd),
    .top_block_lock_strap_b_in (tbl_b),
    .write_protect_strap_b_in  (wp_b),
    .rd_data_out               (rdata),
    .busy_out                  (busy),
    .id_mode_out               (id_mode)
  );

  fil_host_model fil_host_model_i (
    .clk_sys_in  (clk),
    .rst_b_in    (rst_b),
    .rd_data_in  (rdata),
    .addr_out    (addr),
    .wr_data_out (wdata),
    .wr_out      (wr),
    .rd_out      (rd)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ********************************
  // checking helpers
  // ********************************
  task automatic end_sim();
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [18:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    fil_host_model_i.rd(a, d);
    chk(d, exp, msg);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h00, busy}, {7'h00, lvl}, "busy level in time");
    if (busy !== lvl) end_sim();
  endtask

  task automatic chk_id(input logic exp);
    @(posedge clk);
    #1 chk({7'h00, id_mode}, {7'h00, exp}, "id mode flag");
  endtask

  // a refused command must never raise busy
  task automatic chk_busy_low(input string msg);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, busy}, 8'h00, msg);
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_program();
    fil_host_model_i.unlock(8'hA0);
    fil_host_model_i.wr(19'h00000, 8'h3C);
    wait_busy(1'b1, 3);
    rd_chk(19'h00000, 8'h80, "status while programming");
    rd_chk(19'h00000, 8'hC0, "status toggles while programming");
    wait_busy(1'b0, PROG_MAX + 2);
    rd_chk(19'h00000, 8'h3C, "programmed byte");
  endtask

  task automatic t_id_codes();
    fil_host_model_i.wr(19'h05555, 8'hAA);
    repeat (4) @(posedge clk);
    fil_host_model_i.wr(19'h02AAA, 8'h55);
    repeat (4) @(posedge clk);
    fil_host_model_i.wr(19'h05555, 8'h90);
    chk_id(1'b1);
    rd_chk(19'h00000, MFR, "maker code");
    rd_chk(19'h00001, DEV, "device code");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      tbl_b <= ~i[0];
      wp_b <= ~i[1];
      repeat (4) @(posedge clk);
      rd_chk(19'h00002, {4'h0, i[1], i[0], 2'b00}, "strap lock bits");
    end
    @(posedge clk);
    tbl_b <= 1'b1;
    wp_b <= 1'b1;
  endtask

  task automatic t_short_exit();
    fil_host_model_i.wr(19'h41234, 8'hF0);
    chk_id(1'b0);
    rd_chk(19'h00000, 8'h3C, "array after short exit");
  endtask

  task automatic t_long_exit();
    fil_host_model_i.unlock(8'h90);
    chk_id(1'b1);
    fil_host_model_i.unlock(8'hF0);
    chk_id(1'b0);
    rd_chk(19'h00000, 8'h3C, "array after long exit");
  endtask

  task automatic t_erase();
    fil_host_model_i.erase6(19'h00000, 8'h50);
    wait_busy(1'b1, 3);
    fil_host_model_i.unlock(8'h90);
    wait_busy(1'b0, PAGE_LEN + 8);
    chk_id(1'b0);
    rd_chk(19'h00000, 8'hFF, "erased byte");
  endtask

  task automatic t_soft_lock();
    fil_host_model_i.erase6(19'h05555, 8'h40);
    fil_host_model_i.erase6(19'h05555, 8'h70);
    fil_host_model_i.erase6(19'h70000, 8'h30);
    chk_busy_low("sector erase of locked boot block");
    fil_host_model_i.erase6(19'h05555, 8'h10);
    chk_busy_low("chip erase while locked");
    fil_host_model_i.unlock(8'h90);
    rd_chk(19'h00002, 8'h03, "soft lock bits");
  endtask

  task automatic t_power_down();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk_id(1'b0);
    rd_chk(19'h00000, 8'hFF, "array after power down");
    fil_host_model_i.unlock(8'h90);
    rd_chk(19'h00002, 8'h00, "locks after power down");
    fil_host_model_i.wr(19'h00000, 8'hF0);
    chk_id(1'b0);
  endtask

  initial begin
    rst_b = 1'b0;
    tbl_b = 1'b1;
    wp_b = 1'b1;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_program();
    t_id_codes();
    t_short_exit();
    t_long_exit();
    t_erase();
    t_soft_lock();
    t_power_down();
    end_sim();
  end
endmodule
